// ### inc/scp_pkg.sv
// Purpose: constants and types shared by both ends of the safety channel
// Assumes: one clock, frames exchanged as one-cycle strobes
// Notes: checksum is a simple 16-bit sum, stands in for the protocol crc
//
// Notes on behaviour
// - internal error forces safety channel into fail-safe
// - passivated outputs zero, checksum still valid
// - passivated: device fault bit 1 set
// - passivated: safe state bit 4 cleared
// - fail-safe ends only by fix plus reintegration
// - process data keeps flowing if master healthy
// - host stops on passivated data
// - host stops on inconsistent safety data
// - host monitors both status bits, passivation means stop
// - host stops on response timeout
// - host stops on failed parameter check
// - channel compare or internal fault is error
package scp_pkg;
	// ----------------------------------------
	// widths and field positions
	// ----------------------------------------
	localparam int SCP_POS_W = 32;
	localparam int SCP_VEL_W = 16;
	localparam int SCP_CRC_W = 16;
	localparam int SCP_STAT_DEV_FAULT = 1;
	localparam int SCP_VSW_SAFE_STATE = 4;
	localparam logic [7:0] SCP_STAT_RESET = 8'h00;
	localparam logic [15:0] SCP_VSW_RESET = 16'h0000;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int SCP_CLK_MHZ = 200;
	localparam int SCP_TIMEOUT_US = 100;
	localparam int SCP_TIMEOUT_CYC = SCP_TIMEOUT_US * SCP_CLK_MHZ;
	localparam int SCP_MAX_STEP = 1024;

	typedef enum logic [1:0] {
		SCP_RUN = 2'b00,
		SCP_PASSIVE = 2'b01,
		SCP_WAIT_REINT = 2'b10
	} scp_state_t;

	function automatic logic [15:0] scp_crc(input logic [31:0] pos,
		input logic [15:0] vel, input logic [7:0] stat,
		input logic [15:0] vsw);
		logic [15:0] s;
		s = pos[15:0] + pos[31:16];
		s = s + vel + {8'h00, stat} + vsw;
		return s ^ 16'hA5A5;
	endfunction
endpackage

// ### inc/scp_link_if.sv
`timescale 1ns/1ps
interface scp_link_if;
	import scp_pkg::*;
	logic frame_valid;
	logic [31:0] safe_pos;
	logic [15:0] safe_vel;
	logic [7:0] safe_stat;
	logic [15:0] vendor_status_word_one;
	logic [15:0] safe_crc;
	logic pd_valid;
	logic [31:0] pd_pos;
	logic reint_req;
	logic param_write;
	logic [15:0] param_value;
	logic [15:0] param_echo;
	modport device (output frame_valid, safe_pos, safe_vel, safe_stat,
		vendor_status_word_one, safe_crc, pd_valid, pd_pos, param_echo,
		input reint_req, param_write, param_value);
	modport host (input frame_valid, safe_pos, safe_vel, safe_stat,
		vendor_status_word_one, safe_crc, pd_valid, pd_pos, param_echo,
		output reint_req, param_write, param_value);
endinterface

// ### rtl/scp_compare.sv
// Purpose: two-channel position and velocity comparison
// Assumes: both channels sampled in the same cycle
// Notes: velocity is per-sample difference on each channel
`timescale 1ns/1ps
module scp_compare
	import scp_pkg::*;
#(
	parameter int TOL = 4
) (
	input wire logic clk_i,
	input wire logic reset_n_i,
	input wire logic sample_i,
	input wire logic [31:0] pos_a_i,
	input wire logic [31:0] pos_b_i,
	output logic [15:0] vel_o,
	output logic mismatch_o
);
	logic [31:0] last_a;
	logic [31:0] last_b;
	wire [31:0] diff_pos = pos_a_i - pos_b_i;
	wire [31:0] vel_a = pos_a_i - last_a;
	wire [31:0] vel_b = pos_b_i - last_b;
	wire [31:0] diff_vel = vel_a - vel_b;
	wire pos_bad = (diff_pos > 32'(TOL)) && (-diff_pos > 32'(TOL));
	wire vel_bad = (diff_vel > 32'(TOL)) && (-diff_vel > 32'(TOL));

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			last_a <= 32'h00000000;
			last_b <= 32'h00000000;
			vel_o <= 16'h0000;
			mismatch_o <= 1'b0;
		end else if (sample_i) begin
			last_a <= pos_a_i;
			last_b <= pos_b_i;
			vel_o <= vel_a[15:0];
			mismatch_o <= pos_bad || vel_bad;
		end
	end
endmodule

// ### rtl/scp_device.sv
// Purpose: device end, safety channel with latched passivation
// Assumes: scan strobe marks new samples from both channels
// Notes: process data path independent of passivation; a compare
// failure shows one frame late, since its result is registered
`timescale 1ns/1ps
module scp_device
	import scp_pkg::*;
(
	// ----------------------------------------
	// clock and reset
	// ----------------------------------------
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	// ----------------------------------------
	// scanning channels
	// ----------------------------------------
	input wire logic SCAN_STROBE_I,
	input wire logic [31:0] MASTER_POS_I,
	input wire logic [31:0] TEST_POS_I,
	input wire logic MASTER_DIAG_ERR_I,
	input wire logic INTERNAL_FAULT_I,
	// ----------------------------------------
	// status
	// ----------------------------------------
	output logic PASSIVATED_O,
	// ----------------------------------------
	// link
	// ----------------------------------------
	scp_link_if.device LINK
);
	// ----------------------------------------
	// internal signals
	// ----------------------------------------
	// registered link fields; the link sees them only through assigns
	scp_state_t state;
	scp_state_t next_state;
	logic [15:0] vel;
	logic mismatch;
	logic [15:0] param;
	logic frame_valid;
	logic [31:0] frame_pos;
	logic [15:0] frame_vel;
	logic [7:0] frame_stat;
	logic [15:0] frame_vsw;
	logic [15:0] frame_crc;
	logic pd_valid;
	logic [31:0] pd_pos;

	// ----------------------------------------
	// helper functions
	// ----------------------------------------
	// a passivated field reads as zero
	function automatic logic [31:0] gate_word(input logic off,
		input logic [31:0] val);
		return off ? 32'h00000000 : val;
	endfunction

	// single flag at a given bit of a status field
	function automatic logic [15:0] flag_at(input logic flag,
		input int pos);
		return 16'(flag) << pos;
	endfunction

	// ----------------------------------------
	// channel comparison
	// ----------------------------------------
	scp_compare u_scp_compare (
		.clk_i(SYS_CLK_I),
		.reset_n_i(RESET_N_I),
		.sample_i(SCAN_STROBE_I),
		.pos_a_i(MASTER_POS_I),
		.pos_b_i(TEST_POS_I),
		.vel_o(vel),
		.mismatch_o(mismatch)
	);

	// ----------------------------------------
	// error detection
	// ----------------------------------------
	// a failed compare and an internal fault count alike
	wire error_now = mismatch || INTERNAL_FAULT_I;
	wire error_gone = !error_now;
	wire reint_asked = LINK.reint_req;
	wire passive = (state != SCP_RUN);

	// ----------------------------------------
	// passivation state
	// ----------------------------------------
	// error present always wins over a reintegration request
	always_comb begin
		next_state = state;
		case (state)
			SCP_RUN: begin
				if (error_now) begin
					next_state = SCP_PASSIVE;
				end
			end
			SCP_PASSIVE: begin
				if (error_gone) begin
					next_state = SCP_WAIT_REINT;
				end
			end
			SCP_WAIT_REINT: begin
				if (error_now) begin
					next_state = SCP_PASSIVE;
				end else if (reint_asked) begin
					next_state = SCP_RUN;
				end
			end
			default: begin
				next_state = SCP_PASSIVE;
			end
		endcase
	end

	// leaves reset passivated: a fresh start needs reintegration
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			state <= SCP_PASSIVE;
		end else begin
			state <= next_state;
		end
	end

	// ----------------------------------------
	// safety frame contents
	// ----------------------------------------
	wire [15:0] fault_flag = flag_at(passive, SCP_STAT_DEV_FAULT);
	wire [15:0] safe_flag = flag_at(!passive, SCP_VSW_SAFE_STATE);
	wire [31:0] vel_wide = gate_word(passive, {16'h0000, vel});
	wire [31:0] s_pos = gate_word(passive, MASTER_POS_I);
	wire [15:0] s_vel = vel_wide[15:0];
	wire [7:0] s_stat = SCP_STAT_RESET | fault_flag[7:0];
	wire [15:0] s_vsw = SCP_VSW_RESET | safe_flag;
	// checksum over the gated fields, so passive frames stay valid
	wire [15:0] s_crc = scp_crc(s_pos, s_vel, s_stat, s_vsw);

	// one-cycle strobe marks a new frame
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			frame_valid <= 1'b0;
		end else begin
			frame_valid <= SCAN_STROBE_I;
		end
	end

	// fields stand between frames
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			frame_pos <= 32'h00000000;
			frame_vel <= 16'h0000;
			frame_stat <= 8'h00;
			frame_vsw <= 16'h0000;
			frame_crc <= 16'h0000;
		end else if (SCAN_STROBE_I) begin
			frame_pos <= s_pos;
			frame_vel <= s_vel;
			frame_stat <= s_stat;
			frame_vsw <= s_vsw;
			frame_crc <= s_crc;
		end
	end

	// ----------------------------------------
	// process data
	// ----------------------------------------
	// ignores passivation, only master channel health counts
	wire pd_take = SCAN_STROBE_I && !MASTER_DIAG_ERR_I;

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			pd_valid <= 1'b0;
			pd_pos <= 32'h00000000;
		end else begin
			pd_valid <= pd_take;
			if (pd_take) begin
				pd_pos <= MASTER_POS_I;
			end
		end
	end

	// ----------------------------------------
	// parameter echo
	// ----------------------------------------
	// echo lets the host confirm a setting took effect
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			param <= 16'h0000;
		end else if (LINK.param_write) begin
			param <= LINK.param_value;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// every link field comes straight from a flip-flop
	assign LINK.frame_valid = frame_valid;
	assign LINK.safe_pos = frame_pos;
	assign LINK.safe_vel = frame_vel;
	assign LINK.safe_stat = frame_stat;
	assign LINK.vendor_status_word_one = frame_vsw;
	assign LINK.safe_crc = frame_crc;
	assign LINK.pd_valid = pd_valid;
	assign LINK.pd_pos = pd_pos;
	assign LINK.param_echo = param;
	assign PASSIVATED_O = passive;
endmodule

// ### rtl/scp_host.sv
// Purpose: host end, fail-safe checks leading to stop
// Assumes: frames arrive as one-cycle strobes
// Notes: stop is latched until reset; plant must restart deliberately
`timescale 1ns/1ps
module scp_host
	import scp_pkg::*;
#(
	parameter int TIMEOUT_CYC = SCP_TIMEOUT_CYC,
	parameter int MAX_STEP = SCP_MAX_STEP
) (
	// ----------------------------------------
	// clock and reset
	// ----------------------------------------
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	// ----------------------------------------
	// user side
	// ----------------------------------------
	input wire logic REINT_I,
	input wire logic PARAM_WR_I,
	input wire logic [15:0] PARAM_I,
	output logic STOP_O,
	output logic [31:0] POS_O,
	output logic [31:0] PD_POS_O,
	// ----------------------------------------
	// link
	// ----------------------------------------
	scp_link_if.host LINK
);
	logic [31:0] tmo;
	logic [31:0] prev_pos;
	logic have_prev;
	logic chk_pend;
	logic [15:0] param_exp;

	wire crc_ok = LINK.safe_crc == scp_crc(LINK.safe_pos, LINK.safe_vel,
		LINK.safe_stat, LINK.vendor_status_word_one);
	wire passive_rx = LINK.safe_stat[SCP_STAT_DEV_FAULT] ||
		!LINK.vendor_status_word_one[SCP_VSW_SAFE_STATE];
	wire [31:0] step = LINK.safe_pos - prev_pos;
	wire jump = have_prev && (step > 32'(MAX_STEP)) &&
		(-step > 32'(MAX_STEP));
	wire f_ok = LINK.frame_valid && crc_ok;
	wire stop_passive = f_ok && passive_rx;
	wire stop_incons = LINK.frame_valid && (!crc_ok || jump);
	wire stop_tmo = tmo >= 32'(TIMEOUT_CYC);
	wire stop_param = chk_pend && (LINK.param_echo != param_exp);

	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			tmo <= 32'h00000000;
			prev_pos <= 32'h00000000;
			have_prev <= 1'b0;
			chk_pend <= 1'b0;
			param_exp <= 16'h0000;
			STOP_O <= 1'b0;
			POS_O <= 32'h00000000;
			PD_POS_O <= 32'h00000000;
		end else begin
			tmo <= LINK.frame_valid ? 32'h00000000 : tmo + 32'h00000001;
			if (f_ok && !passive_rx) begin
				prev_pos <= LINK.safe_pos;
				have_prev <= 1'b1;
				POS_O <= LINK.safe_pos;
			end
			if (LINK.pd_valid)
				PD_POS_O <= LINK.pd_pos;
			if (PARAM_WR_I)
				param_exp <= PARAM_I;
			chk_pend <= PARAM_WR_I;
			if (stop_passive || stop_incons || stop_tmo || stop_param)
				STOP_O <= 1'b1;
		end
	end

	assign LINK.reint_req = REINT_I;
	assign LINK.param_write = PARAM_WR_I;
	assign LINK.param_value = PARAM_I;
endmodule

// ### verif/scp_chk.sv
// Purpose: link checker, frame contents during passivation
// Assumes: frame fields change only with frame_valid
// Notes: crc worked out here, not taken from the package
`timescale 1ns/1ps
module scp_chk (
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic RESET_N_I,
	// link
	input wire logic frame_valid,
	input wire logic [31:0] safe_pos,
	input wire logic [15:0] safe_vel,
	input wire logic [7:0] safe_stat,
	input wire logic [15:0] vendor_status_word_one,
	input wire logic [15:0] safe_crc,
	input wire logic pd_valid,
	input wire logic [31:0] pd_pos,
	input wire logic reint_req
);
	logic last_fault, reint_seen;
	wire logic flt = frame_valid && safe_stat[1];
	wire logic [15:0] exp_crc = (safe_pos[15:0] + safe_pos[31:16] + safe_vel
		+ {8'h00, safe_stat} + vendor_status_word_one) ^ 16'hA5A5;
	// device leaves reset passivated
	always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
		if (!RESET_N_I) begin
			last_fault <= 1'b1;
			reint_seen <= 1'b0;
		end else begin
			if (frame_valid) last_fault <= safe_stat[1];
			if (frame_valid) reint_seen <= 1'b0;
			if (reint_req) reint_seen <= 1'b1;
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (!RESET_N_I);
	a_pass_pos_zero: assert property (flt |-> safe_pos == 32'h0)
		else $error("passive frame carries position");
	a_pass_vel_zero: assert property (flt |-> safe_vel == 16'h0)
		else $error("passive frame carries velocity");
	a_crc_valid: assert property (
		frame_valid |-> safe_crc == exp_crc)
		else $error("frame checksum wrong");
	a_safe_bit_clear: assert property (
		flt |-> !vendor_status_word_one[4])
		else $error("safe state bit set while passive");
	a_fault_bit_pairs: assert property (
		frame_valid && !vendor_status_word_one[4] |-> safe_stat[1])
		else $error("fault bit clear while safe state bit clear");
	a_exit_needs_reint: assert property (
		frame_valid && !safe_stat[1] && last_fault |-> reint_seen)
		else $error("passivation ended without reintegration");
	a_stat_stands: assert property (!frame_valid |-> $stable(safe_stat))
		else $error("status byte moved between frames");
	a_pos_stands: assert property (!frame_valid |-> $stable(safe_pos))
		else $error("position moved between frames");
	a_pd_stands: assert property (!pd_valid |-> $stable(pd_pos))
		else $error("process data moved without valid");
	c_passive: cover property (flt);
	c_healthy: cover property (frame_valid && !safe_stat[1]);
	c_reint: cover property (reint_req);
endmodule

// ### verif/test_safety_channel_passivation.sv
// Purpose: self-checking bench, device and host joined by the link
// Assumes: host timeout cut to 50 cycles to keep the run short
// Notes: every reset leaves the device passivated
`timescale 1ns/1ps
module test_safety_channel_passivation;
	import scp_pkg::*;
	logic clk, rst_n, strobe, diag_err, fault, reint, pwr, passive, stop;
	logic [31:0] mpos, tpos, pos, pdpos;
	logic [15:0] pval;
	int miscompares, checks;
	scp_link_if link();
	scp_device u_scp_device(.SYS_CLK_I(clk), .RESET_N_I(rst_n),
		.SCAN_STROBE_I(strobe), .MASTER_POS_I(mpos), .TEST_POS_I(tpos),
		.MASTER_DIAG_ERR_I(diag_err), .INTERNAL_FAULT_I(fault),
		.PASSIVATED_O(passive), .LINK(link));
	scp_host #(.TIMEOUT_CYC(50)) u_scp_host(.SYS_CLK_I(clk),
		.RESET_N_I(rst_n), .REINT_I(reint), .PARAM_WR_I(pwr),
		.PARAM_I(pval), .STOP_O(stop), .POS_O(pos), .PD_POS_O(pdpos),
		.LINK(link));
	scp_chk u_scp_chk(.SYS_CLK_I(clk), .RESET_N_I(rst_n),
		.frame_valid(link.frame_valid), .safe_pos(link.safe_pos),
		.safe_vel(link.safe_vel), .safe_stat(link.safe_stat),
		.vendor_status_word_one(link.vendor_status_word_one),
		.safe_crc(link.safe_crc), .pd_valid(link.pd_valid),
		.pd_pos(link.pd_pos), .reint_req(link.reint_req));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	// reint held a few cycles: ignored until the device reaches SCP_WAIT_REINT
	task automatic restart(input logic r);
		rst_n = 1'b0;
		cyc(2);
		rst_n = 1'b1;
		reint = r;
		cyc(4);
		reint = 1'b0;
	endtask
	task automatic scan(input logic [31:0] m, input logic [31:0] t);
		mpos = m;
		tpos = t;
		strobe = 1'b1;
		cyc(1);
		strobe = 1'b0;
		cyc(3);
	endtask
	task automatic stop_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#20000;
		miscompares++;
		stop_test;
	end
	initial begin
		{strobe, diag_err, fault, reint, pwr, rst_n} = '0;
		{mpos, tpos, pval, miscompares, checks} = '0;
		restart(1'b0);
		scan(32'h64, 32'h64);
		chk(32'({passive, link.safe_stat[1],
			link.vendor_status_word_one[4]}), 32'h6);
		chk(link.safe_pos | 32'(link.safe_vel), 32'h0);
		chk(32'(stop), 32'h1);
		restart(1'b1);
		scan(32'h64, 32'h64);
		chk(32'({passive, link.safe_stat[1], stop}), 32'h0);
		pval = 16'h1234;
		pwr = 1'b1;
		cyc(1);
		pwr = 1'b0;
		cyc(2);
		chk({link.param_echo, 15'h0, stop}, 32'h12340000);
		fault = 1'b1;
		scan(32'h65, 32'h65);
		scan(32'h66, 32'h66);
		reint = 1'b1;
		scan(32'h67, 32'h67);
		reint = 1'b0;
		chk(32'({passive, link.safe_stat[1], stop}), 32'h7);
		chk(link.pd_pos, 32'h67);
		chk(pdpos, 32'h67);
		chk(pos, 32'h65);
		fault = 1'b0;
		scan(32'h68, 32'h68);
		chk(32'(passive), 32'h1);
		diag_err = 1'b1;
		scan(32'h69, 32'h69);
		diag_err = 1'b0;
		chk(pdpos, 32'h68);
		restart(1'b1);
		scan(32'h64, 32'h64);
		scan(32'h280, 32'h64);
		scan(32'h280, 32'h280);
		scan(32'h281, 32'h281);
		chk(32'(passive), 32'h1);
		restart(1'b1);
		scan(32'h5, 32'h5);
		scan(32'h1405, 32'h1405);
		chk(32'(stop), 32'h1);
		restart(1'b1);
		cyc(60);
		chk(32'(stop), 32'h1);
		stop_test;
	end
endmodule
